// ==== rtl/cs_builder.sv ====
// Channel status word builder with an AXI4-Lite register slave.
// Assumes frame_strobe pulses once per frame and block_start rides with the first frame.
// Operation
// - Status bit 8n+k sits in byte n bit k
// - Bit 0 consumer, bits 6-7 mode zero
// - Pre-emphasis sets bit 3 only
// - Source number bits 16-19 always zero
// - Channel field 1000 left, 0100 right
// - Rate field 44.1, 48, 32 kHz encodings
// - Clock accuracy bits 28-29 from setting
// - Bits 30 and above sent as zero
// - Category code passed to bits 8-15 unchanged
// - Rate setting 00, 01, 11 map rates
// - Category resets to broadcast reception pattern
// - Validity flag follows the invalid setting
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module cs_builder
   import cs_builder_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        frame_strobe,
   input  wire logic        block_start,
   output cs_frame_out_t    frame_out
);

   // Builds one subframe's status word from the given settings, latched or pending
   function automatic logic [31:0] build_word(input cs_settings_t s, input logic [7:0] cat,
                                              input logic right);
      logic [31:0] w;
      w = '0;
      w[CS_NAUD_POS] = s.nonaudio_flag;
      w[CS_COPY_POS] = s.copyright_free_flag;
      w[CS_PREM_POS] = s.preemphasis_flag;
      w[CS_CAT_LSB +: 8] = cat;
      w[CS_CHAN_LSB +: 4] = right ? CHAN_RIGHT : CHAN_LEFT;
      unique case (s.sample_rate_field)
         RATE_44K1: w[CS_RATE_LSB +: 4] = CS_RATE_44K1;
         RATE_48K:  w[CS_RATE_LSB +: 4] = CS_RATE_48K;
         RATE_32K:  w[CS_RATE_LSB +: 4] = CS_RATE_32K;
         default:   w[CS_RATE_LSB +: 4] = CS_RATE_NREG;
      endcase
      w[CS_ACC_LSB]     = s.clock_accuracy_field[1];
      w[CS_ACC_LSB + 1] = s.clock_accuracy_field[0];
      return w;
   endfunction

   // Address decode shared by read and write
   function automatic logic mapped(input logic [3:0] a, input logic wr);
      return (a == OFF_CTRL) || (a == OFF_CATEGORY) || (!wr && (a == OFF_WORD))
             || (!wr && (a == OFF_POS));
   endfunction

   cs_settings_t  ctrl_q, ctrl_d;
   logic [7:0]    cat_q, cat_d;
   cs_settings_t  live_q, live_d;
   logic [7:0]    live_cat_q, live_cat_d;
   logic [7:0]    pos_q, pos_d;
   cs_frame_out_t out_q, out_d;
   logic          bvalid_q, bvalid_d;
   logic [1:0]    bresp_q, bresp_d;
   logic          rvalid_q, rvalid_d;
   logic [1:0]    rresp_q, rresp_d;
   logic [31:0]   rdata_q, rdata_d;
   logic          wr_go, rd_go;
   logic [31:0]   word_l, word_r, word_nl, word_nr;

   // Handshakes: write address and data taken together, one of each outstanding
   assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
   assign rd_go         = s_axi_arvalid && !rvalid_q;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign frame_out     = out_q;
   assign word_l        = build_word(live_q, live_cat_q, 1'b0);
   assign word_r        = build_word(live_q, live_cat_q, 1'b1);
   assign word_nl       = build_word(ctrl_q, cat_q, 1'b0);   // Words for the next block
   assign word_nr       = build_word(ctrl_q, cat_q, 1'b1);

   // Register bus next state
   always_comb begin
      ctrl_d   = ctrl_q;
      cat_d    = cat_q;
      bvalid_d = bvalid_q && !s_axi_bready;
      bresp_d  = bresp_q;
      rvalid_d = rvalid_q && !s_axi_rready;
      rresp_d  = rresp_q;
      rdata_d  = rdata_q;
      if (wr_go) begin
         bvalid_d = 1'b1;
         bresp_d  = mapped(s_axi_awaddr, 1'b1) ? RESP_OKAY : RESP_SLVERR;
         if (s_axi_wstrb[0] && s_axi_awaddr == OFF_CTRL) begin
            ctrl_d = cs_settings_t'(s_axi_wdata[7:0]);
         end
         if (s_axi_wstrb[0] && s_axi_awaddr == OFF_CATEGORY) begin
            cat_d = s_axi_wdata[7:0];
         end
      end
      if (rd_go) begin
         rvalid_d = 1'b1;
         rresp_d  = mapped(s_axi_araddr, 1'b0) ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr)
            OFF_CTRL:     rdata_d = {24'h000000, ctrl_q};
            OFF_CATEGORY: rdata_d = {24'h000000, cat_q};
            OFF_WORD:     rdata_d = word_l;
            OFF_POS:      rdata_d = {24'h000000, pos_q};
            default:      rdata_d = 32'h00000000;
         endcase
      end
   end

   // Register bus state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q   <= cs_settings_t'(CTRL_RESET);
         cat_q    <= CATEGORY_RESET;
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q  <= RESP_OKAY;
         rdata_q  <= 32'h00000000;
      end else begin
         ctrl_q   <= ctrl_d;
         cat_q    <= cat_d;
         bvalid_q <= bvalid_d;
         bresp_q  <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q  <= rresp_d;
         rdata_q  <= rdata_d;
      end
   end

   // Frame sequencing: latch settings at block start, send one bit per frame
   always_comb begin
      live_d     = live_q;
      live_cat_d = live_cat_q;
      pos_d      = pos_q;
      out_d      = out_q;
      if (frame_strobe) begin
         if (block_start) begin
            live_d     = ctrl_q;
            live_cat_d = cat_q;
            pos_d      = 8'h01;
            out_d.left_bit  = word_nl[0];
            out_d.right_bit = word_nr[0];
            out_d.validity  = ctrl_q.invalid_flag;
         end else begin
            pos_d = (pos_q == BLOCK_LAST) ? 8'h00 : pos_q + 8'h01;
            out_d.left_bit  = (pos_q < WORD_BITS) ? word_l[pos_q[4:0]] : 1'b0;
            out_d.right_bit = (pos_q < WORD_BITS) ? word_r[pos_q[4:0]] : 1'b0;
            out_d.validity  = live_q.invalid_flag;
         end
      end
   end

   // Frame sequencing state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         live_q     <= cs_settings_t'(CTRL_RESET);
         live_cat_q <= CATEGORY_RESET;
         pos_q      <= 8'h00;
         out_q      <= '0;
      end else begin
         live_q     <= live_d;
         live_cat_q <= live_cat_d;
         pos_q      <= pos_d;
         out_q      <= out_d;
      end
   end

   // Checks on the built word and the serial stream
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence block_begin_s;
      frame_strobe && block_start;
   endsequence

   fixed_bits_a: assert property (word_l[0] == 1'b0 && word_l[7:4] == 4'h0
                                  && word_l[19:16] == 4'h0)
      else $error("fixed status bits not zero");
   preemph_only_a: assert property (word_l[CS_PREM_POS] == live_q.preemphasis_flag)
      else $error("pre-emphasis bit mismatch");
   source_zero_a: assert property (word_r[19:16] == 4'h0)
      else $error("source number not zero");
   channel_code_a: assert property (word_l[23:20] == 4'h1 && word_r[23:20] == 4'h2)
      else $error("channel number pattern wrong");
   rate_code_a: assert property (live_q.sample_rate_field == RATE_32K
                                 |-> word_l[27:24] == 4'h3)
      else $error("32 kHz rate code wrong");
   rate_48k_a: assert property (live_q.sample_rate_field == RATE_48K
                                |-> word_l[27:24] == 4'h2)
      else $error("48 kHz rate code wrong");
   accuracy_map_a: assert property (word_l[29:28]
                                    == {live_q.clock_accuracy_field[0],
                                        live_q.clock_accuracy_field[1]})
      else $error("clock accuracy bits wrong");
   reserved_zero_a: assert property (word_l[31:30] == 2'h0)
      else $error("reserved status bits set");
   category_pass_a: assert property (word_r[15:8] == live_cat_q)
      else $error("category code altered");
   block_restart_a: assert property (block_begin_s |=> pos_q == 8'h01
                                     && out_q.left_bit == 1'b0)
      else $error("block did not restart at bit 0");
   latch_hold_a: assert property (!(frame_strobe && block_start)
                                  |=> $stable(live_q))
      else $error("settings changed mid block");
   validity_out_a: assert property (frame_strobe ##1 1'b1
                                    |-> out_q.validity == live_q.invalid_flag)
      else $error("validity flag wrong");
   category_reset_a: assert property ($rose(aresetn) |-> cat_q == 8'h04)
      else $error("category reset value wrong");

endmodule
`default_nettype wire

// ==== rtl/cs_builder_pkg.sv ====
// Constants, field layouts and types for the channel status word builder.
// Assumes a 32-bit AXI4-Lite register bus and one frame strobe per audio frame.
package cs_builder_pkg;

   // Register byte offsets
   localparam logic [3:0] OFF_CTRL     = 4'h0;
   localparam logic [3:0] OFF_CATEGORY = 4'h4;
   localparam logic [3:0] OFF_WORD     = 4'h8;
   localparam logic [3:0] OFF_POS      = 4'hC;

   // Control register field positions
   localparam int CTRL_VALID_BIT = 0;
   localparam int CTRL_NAUD_BIT  = 1;
   localparam int CTRL_COPY_BIT  = 2;
   localparam int CTRL_PREM_BIT  = 3;
   localparam int CTRL_RATE_LSB  = 4;
   localparam int CTRL_ACC_LSB   = 6;

   // Status word field positions
   localparam int CS_NAUD_POS = 1;
   localparam int CS_COPY_POS = 2;
   localparam int CS_PREM_POS = 3;
   localparam int CS_CAT_LSB  = 8;
   localparam int CS_CHAN_LSB = 20;
   localparam int CS_RATE_LSB = 24;
   localparam int CS_ACC_LSB  = 28;

   // Field encodings, bit 0 of each status field constant is the lowest status bit
   localparam logic [3:0] CHAN_LEFT   = 4'h1;
   localparam logic [3:0] CHAN_RIGHT  = 4'h2;
   localparam logic [1:0] RATE_44K1   = 2'h0;
   localparam logic [1:0] RATE_48K    = 2'h1;
   localparam logic [1:0] RATE_32K    = 2'h3;
   localparam logic [3:0] CS_RATE_44K1 = 4'h0;
   localparam logic [3:0] CS_RATE_48K  = 4'h2;
   localparam logic [3:0] CS_RATE_32K  = 4'h3;
   localparam logic [3:0] CS_RATE_NREG = 4'h1;

   // Reset values, block geometry and bus response codes
   localparam logic [7:0]  CATEGORY_RESET = 8'h04;
   localparam logic [7:0]  CTRL_RESET     = 8'h00;
   localparam logic [7:0]  BLOCK_LAST     = 8'hBF;
   localparam logic [7:0]  WORD_BITS      = 8'h20;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // Programmable settings as one carrier
   typedef struct packed {
      logic [1:0] clock_accuracy_field;
      logic [1:0] sample_rate_field;
      logic       preemphasis_flag;
      logic       copyright_free_flag;
      logic       nonaudio_flag;
      logic       invalid_flag;
   } cs_settings_t;

   // Per-frame serial output carrier
   typedef struct packed {
      logic left_bit;
      logic right_bit;
      logic validity;
   } cs_frame_out_t;

endpackage

// ==== verif/cs_receiver.sv ====
// Receiver model: gathers one block of status bits per subframe and one shared block of validity bits.
// Assumes frame_out settles one clock after each frame strobe.
`timescale 1ns/1ps
`default_nettype none
module cs_receiver
   import cs_builder_pkg::*;
(
   input  wire logic          aclk,
   input  wire logic          frame_strobe,
   input  wire logic          block_start,
   input  wire cs_frame_out_t frame_out,
   output logic [191:0]       left_blk,
   output logic [191:0]       right_blk,
   output logic [191:0]       vld_blk
);
   logic [7:0] idx;
   logic       strobe_d;
   // Follow the frame index and store each bit once it has settled
   always @(posedge aclk) begin
      strobe_d <= frame_strobe;
      if (frame_strobe) begin
         idx <= block_start ? 8'h00 : idx + 8'h01;
      end
      if (strobe_d) begin
         left_blk[idx]  <= frame_out.left_bit;
         right_blk[idx] <= frame_out.right_bit;
         vld_blk[idx]   <= frame_out.validity;
      end
   end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Testbench: drives registers over AXI4-Lite and frames, checks whole blocks.
// Assumes the receiver model sits on frame_out.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import cs_builder_pkg::*;
;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, frame_strobe, block_start;
   logic [3:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   cs_frame_out_t frame_out;
   logic [191:0] left_blk, right_blk, vld_blk;
   int err_total, cmp_count;
   logic [7:0] tc[5] = '{8'h19, 8'h76, 8'hA8, 8'hC1, 8'h00};
   logic [7:0] tk[5] = '{8'h01, 8'h03, 8'h80, 8'hFF, 8'h04};
   logic [7:0] cc, ck;
   logic [31:0] got;
   logic [1:0] rs;

   cs_builder i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .frame_strobe(frame_strobe),
      .block_start(block_start), .frame_out(frame_out));
   cs_receiver i_rx (.aclk(aclk), .frame_strobe(frame_strobe), .block_start(block_start),
      .frame_out(frame_out), .left_blk(left_blk), .right_blk(right_blk), .vld_blk(vld_blk));

   // Clock at 20 MHz
   always #25 aclk = ~aclk;

   // Expected status word worked out from the field rules
   function automatic logic [31:0] cs_word(input logic [7:0] c, k, input logic lft);
      logic [31:0] w;
      w = 32'h0;
      w[3:1] = c[3:1];
      w[15:8] = k;
      w[21:20] = lft ? 2'b01 : 2'b10;
      w[25:24] = {c[4], c[5]};
      w[29:28] = {c[6], c[7]};
      return w;
   endfunction

   // Compare tasks, one per kind of result: register word, status block, response
   task automatic compare(input string what, input logic [31:0] exp, got_v);
      cmp_count++;
      if (got_v !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got_v);
      end
   endtask

   task automatic compare_blk(input string what, input logic [191:0] exp, got_v);
      cmp_count++;
      if (got_v !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got_v);
      end
   endtask

   task automatic compare_resp(input string what, input logic [1:0] exp, got_v);
      cmp_count++;
      if (got_v !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got_v);
      end
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // A wait that runs out ends the run
   task automatic tmo(input int n);
      if (n >= 50) begin
         err_total++;
         report_and_stop();
      end
   endtask

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      n = 0;
      do begin @(posedge aclk); n++; end while (awready !== 1'b1 && n < 50);
      tmo(n);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      n = 0;
      do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 50);
      tmo(n);
      compare_resp("bresp", er, bresp);
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      n = 0;
      do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 50);
      tmo(n);
      arvalid <= 1'b0;
      n = 0;
      do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 50);
      tmo(n);
      d = rdata;
      r = rresp;
   endtask

   // One block of 192 frames; new settings written mid-block must not show yet
   task automatic run_block(input logic [7:0] c, k, nc, nk);
      for (int f = 0; f < 192; f++) begin
         frame_strobe <= 1'b1;
         block_start <= (f == 0);
         @(posedge aclk);
         frame_strobe <= 1'b0;
         block_start <= 1'b0;
         @(posedge aclk);
         if (f == 40) begin
            axi_wr(OFF_CTRL, {24'h0, nc}, RESP_OKAY);
            axi_wr(OFF_CATEGORY, {24'h0, nk}, RESP_OKAY);
            axi_rd(OFF_WORD, got, rs);
            compare("word", cs_word(c, k, 1'b1), got);
            compare_resp("rresp", RESP_OKAY, rs);
            axi_rd(OFF_POS, got, rs);
            compare("pos", 32'h0000_0029, got);
         end
      end
      @(posedge aclk);
      compare_blk("left", {160'h0, cs_word(c, k, 1'b1)}, left_blk);
      compare_blk("right", {160'h0, cs_word(c, k, 1'b0)}, right_blk);
      compare_blk("valid", {192{c[0]}}, vld_blk);
      axi_rd(OFF_CTRL, got, rs);
      compare("ctrl", {24'h0, nc}, got);
      $display("block done ctrl %h category %h", c, k);
   endtask

   // Main sequence
   initial begin
      aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; arvalid = 0;
      bready = 1; rready = 1; frame_strobe = 0; block_start = 0;
      awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; err_total = 0; cmp_count = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(OFF_CATEGORY, got, rs);
      compare("category", 32'h04, got);
      compare_resp("rresp", RESP_OKAY, rs);
      axi_rd(4'h2, got, rs);
      compare("unmapped", 32'h0000_0000, got);
      compare_resp("rresp", RESP_SLVERR, rs);
      axi_wr(OFF_WORD, 32'hFFFF_FFFF, RESP_SLVERR);
      cc = 8'h00;
      ck = 8'h04;
      for (int i = 0; i < 5; i++) begin
         run_block(cc, ck, tc[i], tk[i]);
         cc = tc[i];
         ck = tk[i];
      end
      run_block(cc, ck, cc, ck);
      report_and_stop();
   end
endmodule
`default_nettype wire
